// ==== core/psq_defines.svh ====
`ifndef PSQ_DEFINES_SVH
`define PSQ_DEFINES_SVH

// register byte offsets
`define PSQ_CTRL_OFS        12'h000
`define PSQ_LIMIT_OFS       12'h004
`define PSQ_STATUS_OFS      12'h008
`define PSQ_COUNT_OFS       12'h00C

// control register fields
`define PSQ_CTRL_LPOFF_BIT  0
`define PSQ_CTRL_EDGE_BIT   1
`define PSQ_CTRL_OVSD_BIT   2
`define PSQ_CTRL_FSBYP_BIT  3
`define PSQ_CTRL_OFFREQ_BIT 4
`define PSQ_CTRL_OVDIS_BIT  5
`define PSQ_CTRL_RST        6'h00

// limit register fields
`define PSQ_LIM_FAULT_LSB   0
`define PSQ_LIM_FS_LSB      4
`define PSQ_FAULT_LIM_RST   4'hF
`define PSQ_FS_LIM_RST      4'h3

// self-test attempt count, first try included
`define PSQ_SELFTEST_TRIES  2'h3

// timing, in microseconds, and clock rate in MHz
`define PSQ_CLK_MHZ         200
`define PSQ_SHUTDOWN_US     500
`define PSQ_RETRY_US        2000
`define PSQ_HOLD_US         1000
`define PSQ_OV_DBNC_US      100

`endif

// ==== core/psq_pkg.sv ====
package psq_pkg;

  typedef enum logic [3:0] {
    PSQ_LOW_POWER_OFF_STATE,
    PSQ_SELF_TEST,
    PSQ_ST_WAIT,
    PSQ_QUICK_POWER_UP_OFF_STATE,
    PSQ_POWER_UP,
    PSQ_SYS_ON,
    PSQ_PD_REQ,
    PSQ_PD_FAULT,
    PSQ_FS_TRANS,
    PSQ_FS_LOCK
  } psq_state_type;

endpackage : psq_pkg

// ==== core/psq_sequencer.sv ====
`timescale 1ns/1ps
`include "psq_defines.svh"

module psq_sequencer
  import psq_pkg::*;
#(
  parameter int SHUTDOWN_CYC = `PSQ_SHUTDOWN_US * `PSQ_CLK_MHZ,
  parameter int RETRY_CYC    = `PSQ_RETRY_US * `PSQ_CLK_MHZ,
  parameter int HOLD_CYC     = `PSQ_HOLD_US * `PSQ_CLK_MHZ,
  parameter int OV_DBNC_CYC  = `PSQ_OV_DBNC_US * `PSQ_CLK_MHZ
) (
  input  wire logic        pclk,                   // 200 MHz clock
  input  wire logic        presetn,                // async reset, low
  input  wire logic        psel,                   // apb select
  input  wire logic        penable,                // apb enable
  input  wire logic        pwrite,                 // apb direction
  input  wire logic [11:0] paddr,                  // apb byte address
  input  wire logic [31:0] pwdata,                 // apb write data
  output logic      [31:0] prdata,                 // apb read data
  output logic             pready,                 // apb ready
  output logic             pslverr,                // apb error
  input  wire logic        power_on_input,         // power-on pin
  input  wire logic        test_bypass_input,      // test-bypass pin
  input  wire logic        vin_above_uv,           // supply above undervoltage
  input  wire logic        input_overvoltage_flag, // supply above overvoltage
  input  wire logic        thermal_shutdown_flag,  // junction above shutdown
  input  wire logic        trim_load_error_flag,   // trim load failed
  input  wire logic        config_load_error_flag, // config load failed
  input  wire logic        selftest_done,          // self-test finished, pulse
  input  wire logic        selftest_ok,            // self-test result
  input  wire logic        pwrup_reset_step,       // sequencer at reset release
  input  wire logic        pwrup_fail,             // failure during power up
  input  wire logic        pwrdn_done,             // power-down sequence finished
  input  wire logic        fault_timer_expired,    // regulator fault timer
  input  wire logic        fault_event,            // regulator fault, pulse
  output logic             processor_reset_n,      // processor reset, low
  output logic             selftest_start,         // self-test kick, pulse
  output logic             pwrup_run,              // power-up sequence enable
  output logic             pwrdn_run,              // power-down sequence enable
  output logic             failsafe_locked,        // locked in fail-safe
  output logic       [3:0] state_code              // current state
);

  psq_state_type state_q;
  logic [5:0]    ctrl_q;
  logic [3:0]    fault_limit_q;
  logic [3:0]    failsafe_limit_q;
  logic [3:0]    fault_event_counter_q;
  logic [3:0]    failsafe_counter_q;
  logic [1:0]    st_fail_q;
  logic          selftest_error_flag_q;
  logic          power_on_prev_q;
  logic          hold_armed_q;
  logic [19:0]   hold_cnt_q;
  logic [19:0]   ov_cnt_q;
  logic [19:0]   off_cnt_q;
  logic [19:0]   retry_cnt_q;
  logic          processor_reset_n_q;
  logic          selftest_start_q;
  logic [31:0]   prdata_q;
  logic          pready_q;
  logic          pslverr_q;

  logic low_power_off_select;
  logic power_on_edge_mode_cfg;
  logic overvoltage_shutdown_enable;
  logic failsafe_bypass_cfg;
  logic turn_off_request_bit;
  logic ov_disable;
  logic power_on_fall;
  logic supply_ok;
  logic load_ok;
  logic qual_ok;
  logic pu_event;
  logic sys_fault;
  logic ov_expired;
  logic hold_expired;
  logic off_expired;
  logic wr_en;
  logic rd_setup;

  assign low_power_off_select        = ctrl_q[`PSQ_CTRL_LPOFF_BIT];
  assign power_on_edge_mode_cfg      = ctrl_q[`PSQ_CTRL_EDGE_BIT];
  assign overvoltage_shutdown_enable = ctrl_q[`PSQ_CTRL_OVSD_BIT];
  assign failsafe_bypass_cfg         = ctrl_q[`PSQ_CTRL_FSBYP_BIT];
  assign turn_off_request_bit        = ctrl_q[`PSQ_CTRL_OFFREQ_BIT];
  assign ov_disable                  = ctrl_q[`PSQ_CTRL_OVDIS_BIT];

  // power-on event in the selected mode
  function automatic logic on_event(input logic edge_mode, input logic lvl, input logic fall);
    on_event = edge_mode ? fall : lvl;
  endfunction : on_event

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `PSQ_CTRL_OFS) || (a == `PSQ_LIMIT_OFS) ||
               (a == `PSQ_STATUS_OFS) || (a == `PSQ_COUNT_OFS);
  endfunction : addr_hit

  assign power_on_fall = power_on_prev_q && !power_on_input;
  assign supply_ok     = vin_above_uv && (ov_disable || !input_overvoltage_flag);
  assign load_ok       = !trim_load_error_flag && !config_load_error_flag;
  assign qual_ok       = supply_ok && !thermal_shutdown_flag && load_ok &&
                         !selftest_error_flag_q;
  assign pu_event      = on_event(power_on_edge_mode_cfg, power_on_input, power_on_fall);
  assign sys_fault     = fault_timer_expired || thermal_shutdown_flag ||
                         (fault_event_counter_q == fault_limit_q);
  assign ov_expired    = ov_cnt_q >= 20'(OV_DBNC_CYC);
  assign hold_expired  = hold_cnt_q > 20'(HOLD_CYC);
  assign off_expired   = off_cnt_q >= 20'(SHUTDOWN_CYC);
  assign wr_en         = psel && penable && pready_q && pwrite && !pslverr_q;
  assign rd_setup      = psel && !penable;

  // main state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= PSQ_LOW_POWER_OFF_STATE;
    end else begin
      case (state_q)
        PSQ_LOW_POWER_OFF_STATE: begin
          // off select clear and no bypass: wait for a real event
          if (low_power_off_select || test_bypass_input) begin
            state_q <= PSQ_SELF_TEST;
          end else if (pu_event && supply_ok && !thermal_shutdown_flag && load_ok) begin
            state_q <= PSQ_SELF_TEST;
          end
        end
        PSQ_SELF_TEST: begin
          if (selftest_done) begin
            if (selftest_ok) begin
              state_q <= PSQ_QUICK_POWER_UP_OFF_STATE;
            end else if (st_fail_q == `PSQ_SELFTEST_TRIES - 2'h1) begin
              state_q <= test_bypass_input ? PSQ_QUICK_POWER_UP_OFF_STATE : PSQ_FS_TRANS;
            end else begin
              state_q <= PSQ_ST_WAIT;
            end
          end
        end
        PSQ_ST_WAIT: begin
          if (retry_cnt_q >= 20'(RETRY_CYC)) begin
            state_q <= PSQ_SELF_TEST;
          end
        end
        PSQ_QUICK_POWER_UP_OFF_STATE: begin
          if (qual_ok) begin
            if (!low_power_off_select && !test_bypass_input) begin
              state_q <= PSQ_POWER_UP;
            end else if (pu_event) begin
              state_q <= PSQ_POWER_UP;
            end
          end
        end
        PSQ_POWER_UP: begin
          if (pwrup_fail) begin
            state_q <= PSQ_PD_FAULT;
          end else if (pwrup_reset_step) begin
            state_q <= PSQ_SYS_ON;
          end
        end
        PSQ_SYS_ON: begin
          // faults outrank every requested turn off
          if (sys_fault) begin
            state_q <= PSQ_PD_FAULT;
          end else if (overvoltage_shutdown_enable && ov_expired) begin
            state_q <= PSQ_PD_REQ;
          end else if (!power_on_edge_mode_cfg && !power_on_input) begin
            state_q <= PSQ_PD_REQ;
          end else if (power_on_edge_mode_cfg && hold_expired) begin
            state_q <= PSQ_PD_REQ;
          end else if (turn_off_request_bit && off_expired) begin
            state_q <= PSQ_PD_REQ;
          end
        end
        PSQ_PD_REQ: begin
          if (pwrdn_done) begin
            state_q <= PSQ_LOW_POWER_OFF_STATE;
          end
        end
        PSQ_PD_FAULT: begin
          if (pwrdn_done) begin
            state_q <= PSQ_FS_TRANS;
          end
        end
        PSQ_FS_TRANS: begin
          if (failsafe_bypass_cfg || failsafe_counter_q < failsafe_limit_q) begin
            state_q <= PSQ_LOW_POWER_OFF_STATE;
          end else begin
            state_q <= PSQ_FS_LOCK;
          end
        end
        PSQ_FS_LOCK: state_q <= PSQ_FS_LOCK;
        default:     state_q <= PSQ_LOW_POWER_OFF_STATE;
      endcase
    end
  end

  // fail-safe counter; bumped as the transition state is entered, so it is
  // already counted when the transition state decides
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      failsafe_counter_q <= 4'h0;
    end else if (state_q != PSQ_FS_TRANS && state_q != PSQ_FS_LOCK &&
                 ((state_q == PSQ_PD_FAULT && pwrdn_done) ||
                  (state_q == PSQ_SELF_TEST && selftest_done && !selftest_ok &&
                   st_fail_q == `PSQ_SELFTEST_TRIES - 2'h1 && !test_bypass_input)) &&
                 failsafe_counter_q < failsafe_limit_q) begin
      failsafe_counter_q <= failsafe_counter_q + 4'h1;
    end
  end

  // self-test failure count and sticky error flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_fail_q             <= 2'h0;
      selftest_error_flag_q <= 1'b0;
    end else if (state_q == PSQ_SELF_TEST && selftest_done) begin
      if (selftest_ok) begin
        st_fail_q             <= 2'h0;
        selftest_error_flag_q <= 1'b0;
      end else if (st_fail_q == `PSQ_SELFTEST_TRIES - 2'h1) begin
        st_fail_q             <= 2'h0;
        selftest_error_flag_q <= 1'b1;
      end else begin
        st_fail_q <= st_fail_q + 2'h1;
      end
    end
  end

  // kick a self-test on each entry into the test state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selftest_start_q <= 1'b0;
    end else begin
      selftest_start_q <= ((state_q == PSQ_LOW_POWER_OFF_STATE) || (state_q == PSQ_ST_WAIT)) &&
                          ((state_q == PSQ_ST_WAIT) ? retry_cnt_q >= 20'(RETRY_CYC) :
                           (low_power_off_select || test_bypass_input ||
                            (pu_event && supply_ok && !thermal_shutdown_flag && load_ok)));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retry_cnt_q <= 20'h00000;
    end else if (state_q == PSQ_ST_WAIT) begin
      retry_cnt_q <= retry_cnt_q + 20'h00001;
    end else begin
      retry_cnt_q <= 20'h00000;
    end
  end

  // power-on history and edge-mode hold timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_on_prev_q <= 1'b0;
      hold_armed_q    <= 1'b0;
      hold_cnt_q      <= 20'h00000;
    end else begin
      power_on_prev_q <= power_on_input;
      if (state_q != PSQ_SYS_ON || power_on_input) begin
        hold_armed_q <= 1'b0;
        hold_cnt_q   <= 20'h00000;
      end else if (power_on_fall) begin
        hold_armed_q <= 1'b1;
        hold_cnt_q   <= 20'h00001;
      end else if (hold_armed_q && !hold_expired) begin
        hold_cnt_q <= hold_cnt_q + 20'h00001;
      end
    end
  end

  // overvoltage debounce; restarts whenever the flag drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_cnt_q <= 20'h00000;
    end else if (!input_overvoltage_flag) begin
      ov_cnt_q <= 20'h00000;
    end else if (!ov_expired) begin
      ov_cnt_q <= ov_cnt_q + 20'h00001;
    end
  end

  // shutdown timer runs in system on while the turn-off request stands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_cnt_q <= 20'h00000;
    end else if (!turn_off_request_bit || state_q != PSQ_SYS_ON) begin
      off_cnt_q <= 20'h00000;
    end else if (!off_expired) begin
      off_cnt_q <= off_cnt_q + 20'h00001;
    end
  end

  // fault events count between power ups, saturating at the limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_event_counter_q <= 4'h0;
    end else if (state_q == PSQ_QUICK_POWER_UP_OFF_STATE) begin
      fault_event_counter_q <= 4'h0;
    end else if (fault_event && fault_event_counter_q != fault_limit_q) begin
      fault_event_counter_q <= fault_event_counter_q + 4'h1;
    end
  end

  // processor reset released as system on is entered, driven low again one cycle after it is left
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      processor_reset_n_q <= 1'b0;
    end else begin
      processor_reset_n_q <= (state_q == PSQ_POWER_UP && pwrup_reset_step && !pwrup_fail) ||
                             (state_q == PSQ_SYS_ON);
    end
  end

  // control and limit registers; the turn-off bit self-clears on power down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q           <= `PSQ_CTRL_RST;
      fault_limit_q    <= `PSQ_FAULT_LIM_RST;
      failsafe_limit_q <= `PSQ_FS_LIM_RST;
    end else begin
      if (wr_en && paddr == `PSQ_CTRL_OFS) begin
        ctrl_q <= pwdata[5:0];
      end else if (state_q == PSQ_PD_REQ || state_q == PSQ_PD_FAULT) begin
        ctrl_q[`PSQ_CTRL_OFFREQ_BIT] <= 1'b0;
      end
      if (wr_en && paddr == `PSQ_LIMIT_OFS) begin
        fault_limit_q    <= pwdata[`PSQ_LIM_FAULT_LSB +: 4];
        failsafe_limit_q <= pwdata[`PSQ_LIM_FS_LSB +: 4];
      end
    end
  end

  // apb slave: answer in the first access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else if (rd_setup) begin
      pready_q  <= 1'b1;
      pslverr_q <= !addr_hit(paddr);
      case (paddr)
        `PSQ_CTRL_OFS:   prdata_q <= {26'h0000000, ctrl_q};
        `PSQ_LIMIT_OFS:  prdata_q <= {24'h000000, failsafe_limit_q, fault_limit_q};
        `PSQ_STATUS_OFS: prdata_q <= {25'h0000000, selftest_error_flag_q,
                                      processor_reset_n_q, 1'b0, state_q};
        `PSQ_COUNT_OFS:  prdata_q <= {22'h000000, st_fail_q, failsafe_counter_q,
                                      fault_event_counter_q};
        default:         prdata_q <= 32'h00000000;
      endcase
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end
  end

  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign processor_reset_n = processor_reset_n_q;
  assign selftest_start    = selftest_start_q;
  assign state_code        = state_q;
  assign pwrup_run         = state_q == PSQ_POWER_UP;
  assign pwrdn_run         = (state_q == PSQ_PD_REQ) || (state_q == PSQ_PD_FAULT);
  assign failsafe_locked   = state_q == PSQ_FS_LOCK;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_QPU_DIRECT: assert property (
    state_q == PSQ_QUICK_POWER_UP_OFF_STATE && !low_power_off_select && !test_bypass_input && qual_ok
    |=> state_q == PSQ_POWER_UP) else $error("direct power up missed");

  AST_LEVEL_ON: assert property (
    state_q == PSQ_QUICK_POWER_UP_OFF_STATE && low_power_off_select && !power_on_edge_mode_cfg &&
    power_on_input && qual_ok |=> state_q == PSQ_POWER_UP)
    else $error("level power-on ignored");

  AST_EDGE_ON: assert property (
    state_q == PSQ_QUICK_POWER_UP_OFF_STATE && power_on_edge_mode_cfg && $past(power_on_input) &&
    !power_on_input && qual_ok |=> state_q == PSQ_POWER_UP)
    else $error("edge power-on ignored");

  AST_QUAL_BLOCK: assert property (
    state_q == PSQ_QUICK_POWER_UP_OFF_STATE && (thermal_shutdown_flag || trim_load_error_flag)
    |=> state_q == PSQ_QUICK_POWER_UP_OFF_STATE) else $error("power up without qualifiers");

  AST_RESET_SYSON: assert property (
    state_q == PSQ_SYS_ON |-> processor_reset_n) else $error("system on under reset");

  AST_LEVEL_OFF: assert property (
    state_q == PSQ_SYS_ON && !sys_fault && !power_on_edge_mode_cfg && !power_on_input &&
    !(overvoltage_shutdown_enable && ov_expired) |=> state_q == PSQ_PD_REQ)
    else $error("level turn off missed");

  AST_THERMAL: assert property (
    state_q == PSQ_SYS_ON && thermal_shutdown_flag |=> state_q == PSQ_PD_FAULT)
    else $error("thermal fault missed");

  AST_REQ_DONE: assert property (
    state_q == PSQ_PD_REQ && pwrdn_done |=> state_q == PSQ_LOW_POWER_OFF_STATE)
    else $error("requested power down did not end off");

  AST_FAULT_DONE: assert property (
    state_q == PSQ_PD_FAULT && pwrdn_done |=> state_q == PSQ_FS_TRANS ##1
    state_q != PSQ_FS_TRANS) else $error("fault power down did not reach fail-safe");

  AST_FS_LOCK: assert property (
    state_q == PSQ_FS_TRANS && !failsafe_bypass_cfg &&
    failsafe_counter_q == failsafe_limit_q |=> state_q == PSQ_FS_LOCK)
    else $error("fail-safe lock missed");

endmodule : psq_sequencer

// ==== sim/psq_host_model.sv ====
`timescale 1ns/1ps
module psq_host_model (
  input  wire logic       pclk,              // system clock
  input  wire logic       presetn,           // async reset, low
  input  wire logic       want_on,           // requested pin level
  input  wire logic       processor_reset_n, // reset from sequencer
  output logic            power_on_input,    // power-on pin
  output logic      [3:0] boot_cnt           // boots seen
);
  logic reset_n_q;
  // pin moves only after an edge, so every level and fall is held a full cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_on_input <= 1'b0;
      reset_n_q      <= 1'b0;
      boot_cnt       <= 4'h0;
    end else begin
      power_on_input <= want_on;
      reset_n_q      <= processor_reset_n;
      if (processor_reset_n && !reset_n_q) begin
        boot_cnt <= boot_cnt + 4'h1;
      end
    end
  end
endmodule : psq_host_model

// ==== sim/psq_sequencer_tb_top.sv ====
`timescale 1ns/1ps
`include "psq_defines.svh"
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin mismatches++; \
  $display("BAD %s exp %0h got %0h", nm, e, s); end end
`define PULSE(s) begin @(posedge pclk); s <= 1'b1; @(posedge pclk); s <= 1'b0; end
module psq_sequencer_tb_top
  import psq_pkg::*;
;
  localparam int HOLD = 8;
  localparam int SHUT = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, want_on;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        power_on_input, test_bypass_input, vin_above_uv, input_overvoltage_flag;
  logic        thermal_shutdown_flag, trim_load_error_flag, config_load_error_flag;
  logic        selftest_done, selftest_ok, pwrup_reset_step, pwrup_fail, pwrdn_done;
  logic        fault_timer_expired, fault_event, processor_reset_n, selftest_start;
  logic        pwrup_run, pwrdn_run, failsafe_locked;
  logic [3:0]  state_code, boot_cnt;
  int          mismatches, checks_done, k;

  psq_sequencer #(.SHUTDOWN_CYC(SHUT), .RETRY_CYC(10), .HOLD_CYC(HOLD), .OV_DBNC_CYC(5)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .power_on_input, .test_bypass_input, .vin_above_uv, .input_overvoltage_flag,
    .thermal_shutdown_flag, .trim_load_error_flag, .config_load_error_flag, .selftest_done,
    .selftest_ok, .pwrup_reset_step, .pwrup_fail, .pwrdn_done, .fault_timer_expired,
    .fault_event, .processor_reset_n, .selftest_start, .pwrup_run, .pwrdn_run,
    .failsafe_locked, .state_code);
  psq_host_model host (.pclk, .presetn, .want_on, .processor_reset_n, .power_on_input,
    .boot_cnt);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // self-test engine stand-in: answers every kick one cycle later
  always @(posedge pclk) selftest_done <= selftest_start;

  task final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) mismatches++;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task wait_st(input psq_state_type e);
    int n;
    n = 0;
    while (state_code !== e && n < 60) begin @(posedge pclk); n++; end
    `CHK("state", e, state_code)
  endtask : wait_st

  task on_up;
    `CHK("pwrup_run", 1'b1, pwrup_run)
    `PULSE(pwrup_reset_step)
    wait_st(PSQ_SYS_ON);
    `CHK("reset_n", 1'b1, processor_reset_n)
  endtask : on_up

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    final_report();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, want_on, test_bypass_input} = '0;
    {input_overvoltage_flag, thermal_shutdown_flag, trim_load_error_flag} = '0;
    {config_load_error_flag, pwrup_reset_step, pwrup_fail, pwrdn_done} = '0;
    {fault_timer_expired, fault_event, selftest_done} = '0;
    {vin_above_uv, selftest_ok} = 2'b11;
    k = $urandom(32'hC4DE);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `PSQ_LIMIT_OFS, 32'h0);
    `CHK("limit", 32'h0000_003F, rd)
    apb(1'b1, 12'h010, $urandom);
    `CHK("slverr", 1'b1, err)
    repeat (6) @(posedge pclk);
    `CHK("state", PSQ_LOW_POWER_OFF_STATE, state_code)
    want_on <= 1'b1;
    wait_st(PSQ_POWER_UP);
    `PULSE(pwrup_fail)
    wait_st(PSQ_PD_FAULT);
    want_on <= 1'b0;
    `PULSE(pwrdn_done)
    wait_st(PSQ_FS_TRANS);
    wait_st(PSQ_LOW_POWER_OFF_STATE);
    apb(1'b0, `PSQ_COUNT_OFS, 32'h0);
    `CHK("fs count", 4'h1, rd[7:4])
    apb(1'b1, `PSQ_CTRL_OFS, 32'h1);
    wait_st(PSQ_QUICK_POWER_UP_OFF_STATE);
    k = $urandom % 4;
    case (k)
      0: thermal_shutdown_flag <= 1'b1;
      1: trim_load_error_flag <= 1'b1;
      2: config_load_error_flag <= 1'b1;
      default: vin_above_uv <= 1'b0;
    endcase
    want_on <= 1'b1;
    repeat (5) @(posedge pclk);
    `CHK("state", PSQ_QUICK_POWER_UP_OFF_STATE, state_code)
    {thermal_shutdown_flag, trim_load_error_flag, config_load_error_flag} <= 3'b0;
    vin_above_uv <= 1'b1;
    wait_st(PSQ_POWER_UP);
    on_up();
    want_on <= 1'b0;
    wait_st(PSQ_PD_REQ);
    `CHK("pwrdn_run", 1'b1, pwrdn_run)
    `PULSE(pwrdn_done)
    wait_st(PSQ_LOW_POWER_OFF_STATE);
    `CHK("boots", 4'h1, boot_cnt)
    apb(1'b1, `PSQ_CTRL_OFS, 32'h3);
    wait_st(PSQ_QUICK_POWER_UP_OFF_STATE);
    want_on <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK("state", PSQ_QUICK_POWER_UP_OFF_STATE, state_code)
    want_on <= 1'b0;
    wait_st(PSQ_POWER_UP);
    on_up();
    want_on <= 1'b1;
    repeat (3) @(posedge pclk);
    want_on <= 1'b0;
    repeat (HOLD - 1) @(posedge pclk);
    `CHK("state", PSQ_SYS_ON, state_code)
    wait_st(PSQ_PD_REQ);
    `PULSE(pwrdn_done)
    wait_st(PSQ_QUICK_POWER_UP_OFF_STATE);
    apb(1'b1, `PSQ_CTRL_OFS, 32'h1);
    want_on <= 1'b1;
    wait_st(PSQ_POWER_UP);
    on_up();
    apb(1'b1, `PSQ_CTRL_OFS, 32'h5);
    input_overvoltage_flag <= 1'b1;
    wait_st(PSQ_PD_REQ);
    input_overvoltage_flag <= 1'b0;
    `PULSE(pwrdn_done)
    wait_st(PSQ_POWER_UP);
    on_up();
    apb(1'b1, `PSQ_CTRL_OFS, 32'h11);
    repeat (SHUT / 2) @(posedge pclk);
    `CHK("state", PSQ_SYS_ON, state_code)
    wait_st(PSQ_PD_REQ);
    `PULSE(pwrdn_done)
    apb(1'b1, `PSQ_LIMIT_OFS, 32'h31);
    for (int i = 0; i < 2; i++) begin
      wait_st(PSQ_POWER_UP);
      on_up();
      if (i == 0 && $urandom % 2) thermal_shutdown_flag <= 1'b1;
      else if (i == 0) fault_timer_expired <= 1'b1;
      else `PULSE(fault_event)
      wait_st(PSQ_PD_FAULT);
      {thermal_shutdown_flag, fault_timer_expired} <= 2'b0;
      `PULSE(pwrdn_done)
      wait_st(PSQ_FS_TRANS);
      wait_st(i == 0 ? PSQ_LOW_POWER_OFF_STATE : PSQ_FS_LOCK);
    end
    `CHK("locked", 1'b1, failsafe_locked)
    // mid-run reset: test bypass lets a level event start power up
    presetn <= 1'b0;
    test_bypass_input <= 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_st(PSQ_POWER_UP);
    // second reset: failing self-test retries, then fail-safe transition
    presetn <= 1'b0;
    test_bypass_input <= 1'b0;
    selftest_ok <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_st(PSQ_ST_WAIT);
    wait_st(PSQ_FS_TRANS);
    wait_st(PSQ_LOW_POWER_OFF_STATE);
    final_report();
  end
endmodule : psq_sequencer_tb_top
